/* rtl/supervision_timer_pkg.sv */
// package: constants for the supervision timer block
// assumes a single 100 MHz system clock; rc tick enable made by a divider
// Summary of operation
// - retriggerable one-shot counter resets the core at terminal count
// - first service instruction starts timer, later ones restart timeout
// - service instruction updates zero, sign and overflow flags
// - timer counts on its own rc oscillator tick, not the system clock
// - mode bits 1:0 select counter tap, hence minimum timeout
// - mode bit 2 keeps timer running in halt, bit 3 in stop
// - mode bits 7:4 reserved, no function
// - mode writes accepted only in first 60 cycles after qualifying reset
// - after window closes every mode write is blocked until next reset or stop recovery
// - mode register is write-only, reads return no contents
// - mode register decoded in expanded bank f at location 0fh
package supervision_timer_pkg;
	localparam logic [3:0] MODE_BANK = 4'hf;
	localparam logic [7:0] MODE_ADDR = 8'h0f;
	localparam logic [7:0] STATUS_ADDR = 8'h0e;
	localparam logic [7:0] MODE_RESET = 8'h0d;
	localparam int TAP_LSB = 0;
	localparam int HALT_RUN_BIT = 2;
	localparam int STOP_RUN_BIT = 3;
	localparam int WINDOW_CYCLES = 60;
	localparam int RC_DIV_DEFAULT = 8;
	localparam int CNT_W = 21;
	localparam int TAP_SHIFT_BASE = 14;
	localparam int FLAG_Z = 2;
	localparam int FLAG_S = 1;
	localparam int FLAG_V = 0;
	// terminal count for a tap code: each step quadruples the period
	// one bit wider than the largest shift, so tap 3 does not wrap to zero
	function automatic logic [CNT_W-1:0] tap_limit(input logic [1:0] tap);
		tap_limit = CNT_W'(1) << (TAP_SHIFT_BASE + 32'(tap) * 2);
	endfunction : tap_limit
endpackage : supervision_timer_pkg

/* rtl/rc_tick_divider.sv */
// rc_tick_divider: stands in for the on-board rc oscillator as an enable
// assumes one system clock; runs freely, independent of core clock gating
`timescale 1ns/1ns
module rc_tick_divider
	import supervision_timer_pkg::*;
#(
	parameter int DIV = RC_DIV_DEFAULT
)(
	input wire logic clock_in,
	input wire logic resetn_in,
	output logic tick_out
);
	logic [15:0] div_reg;
	logic [15:0] div_next;
	logic tick_reg;
	logic tick_next;

	// count down, pulse once per wrap
	always_comb
	begin
		tick_next = (div_reg == 16'h0000);
		div_next = tick_next ? 16'(DIV - 1) : div_reg - 16'h0001;
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_out = tick_reg;
endmodule : rc_tick_divider

/* rtl/mode_access_window.sv */
// mode_access_window: counts processor cycles after a qualifying reset
// assumes cycle_en pulses once per processor cycle, first_instr_in on first fetch
`timescale 1ns/1ns
module mode_access_window
	import supervision_timer_pkg::*;
#(
	parameter int CYCLES = WINDOW_CYCLES
)(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic rearm_in,
	input wire logic first_instr_in,
	input wire logic cycle_en_in,
	output logic open_out
);
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic started_reg;
	logic started_next;

	// window open from reset or rearm; counting starts at the first instruction, closes after the cycle budget
	always_comb
	begin
		started_next = started_reg;
		count_next = count_reg;
		if (rearm_in)
		begin
			started_next = 1'b0;
			count_next = 8'h00;
		end
		else
		begin
			if (first_instr_in)
				started_next = 1'b1;
			if ((started_reg || first_instr_in) && cycle_en_in &&
				count_reg < 8'(CYCLES))
				count_next = count_reg + 8'h01;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			count_reg <= 8'h00;
			started_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			started_reg <= started_next;
		end
	end

	// closed window stays closed until the next rearm
	assign open_out = (count_reg < 8'(CYCLES));
endmodule : mode_access_window

/* rtl/supervision_timer.sv */
// supervision_timer: retriggerable watchdog with a mode register writable while the access window is open
// assumes the core reports service instructions, halt and stop as levels
// and pulses, and applies core_reset_out as a reset of its own
`timescale 1ns/1ns
module supervision_timer
	import supervision_timer_pkg::*;
#(
	parameter int RC_DIV = RC_DIV_DEFAULT,
	parameter int WIN_CYCLES = WINDOW_CYCLES
)(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [3:0] bank_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic service_in,
	input wire logic [7:0] flags_in,
	output logic [7:0] flags_out,
	output logic flags_we_out,
	input wire logic halt_in,
	input wire logic stop_in,
	input wire logic stop_recover_in,
	input wire logic first_instr_in,
	input wire logic cycle_en_in,
	output logic core_reset_out,
	output logic running_out
);
	logic rc_tick;
	logic window_open;
	logic rearm;
	logic [7:0] mode_reg;
	logic [7:0] mode_next;
	logic running_reg;
	logic running_next;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic reset_reg;
	logic reset_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic flags_we_reg;
	logic flags_we_next;
	logic mode_hit;
	logic count_en;

	rc_tick_divider #(
		.DIV(RC_DIV)
	) u_tick (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.tick_out(rc_tick)
	);

	// the own timeout reset and stop recovery both reopen the window
	assign rearm = reset_reg | stop_recover_in;

	mode_access_window #(
		.CYCLES(WIN_CYCLES)
	) u_window (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.rearm_in(rearm),
		.first_instr_in(first_instr_in),
		.cycle_en_in(cycle_en_in),
		.open_out(window_open)
	);

	// address decode of the mode register in expanded bank f
	assign mode_hit = (bank_in == MODE_BANK) && (addr_in == MODE_ADDR);

	// counting gated by halt and stop according to the mode bits
	assign count_en = rc_tick && running_reg &&
		!(halt_in && !mode_reg[HALT_RUN_BIT]) &&
		!(stop_in && !mode_reg[STOP_RUN_BIT]);

	// mode register: accepted only while the window is open
	always_comb
	begin
		mode_next = mode_reg;
		if (rearm)
			mode_next = MODE_RESET;
		else if (wr_in && mode_hit && window_open)
			mode_next = {4'h0, wdata_in[3:0]};
	end

	// timer core: start, refresh, count and fire
	always_comb
	begin
		running_next = running_reg;
		count_next = count_reg;
		reset_next = 1'b0;
		if (reset_reg)
		begin
			running_next = 1'b0; // core reset disables until next service
			count_next = '0;
		end
		else if (service_in)
		begin
			running_next = 1'b1;
			count_next = '0;
		end
		else if (count_en)
		begin
			if (count_reg + CNT_W'(1) >= tap_limit(mode_reg[TAP_LSB +: 2]))
			begin
				reset_next = 1'b1;
				count_next = '0;
			end
			else
				count_next = count_reg + CNT_W'(1);
		end
	end

	// service instruction writes z, s and v; the rest pass unchanged
	always_comb
	begin
		flags_next = flags_in;
		flags_we_next = service_in;
		if (service_in)
		begin
			flags_next[FLAG_Z] = 1'b0;
			flags_next[FLAG_S] = 1'b0;
			flags_next[FLAG_V] = 1'b0;
		end
	end

	// read port: mode register gives nothing back, status shows state
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_in && bank_in == MODE_BANK && addr_in == STATUS_ADDR)
			rdata_next = {6'h00, window_open, running_reg};
		else if (rd_in && mode_hit)
			rdata_next = 8'h00;
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			mode_reg <= MODE_RESET;
			running_reg <= 1'b0;
			count_reg <= '0;
			reset_reg <= 1'b0;
			rdata_reg <= 8'h00;
			flags_reg <= 8'h00;
			flags_we_reg <= 1'b0;
		end
		else
		begin
			mode_reg <= mode_next;
			running_reg <= running_next;
			count_reg <= count_next;
			reset_reg <= reset_next;
			rdata_reg <= rdata_next;
			flags_reg <= flags_next;
			flags_we_reg <= flags_we_next;
		end
	end

	assign rdata_out = rdata_reg;
	assign flags_out = flags_reg;
	assign flags_we_out = flags_we_reg;
	assign core_reset_out = reset_reg;
	assign running_out = running_reg;
endmodule : supervision_timer

/* sim/supervision_timer_checker.sv */
// checker: port timing of the supervision timer
// assumes one clock domain; attached to the design by the bind below
`timescale 1ns/1ns
module supervision_timer_checker (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic service_in,
	input wire logic [7:0] flags_out,
	input wire logic flags_we_out,
	input wire logic core_reset_out,
	input wire logic running_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	// a service is answered one cycle later
	property p_we; service_in |=> flags_we_out; endproperty
	a_we: assert property (p_we) else $error("no flag write");
	property p_fl; service_in |=> flags_out[2:0] == 3'h0; endproperty
	a_fl: assert property (p_fl) else $error("flags kept");
	property p_run; service_in |=> running_out; endproperty
	a_run: assert property (p_run) else $error("not running");
	property p_rise; $rose(running_out) |-> $past(service_in); endproperty
	a_rise: assert property (p_rise) else $error("self start");
	// a restart must leave room before any reset
	property p_hold; service_in |=> !core_reset_out [*8]; endproperty
	a_hold: assert property (p_hold) else $error("early reset");
	property p_pulse; core_reset_out |=> !core_reset_out; endproperty
	a_pulse: assert property (p_pulse) else $error("long reset");
	property p_stop; core_reset_out |=> !running_out; endproperty
	a_stop: assert property (p_stop) else $error("runs on");
	// read data only stand after a read strobe
	property p_idle; !rd_in |=> rdata_out == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("stray data");
endmodule : supervision_timer_checker
bind supervision_timer supervision_timer_checker supervision_timer_checker_i
	(.clock_in, .resetn_in, .rd_in, .rdata_out, .service_in, .flags_out,
	.flags_we_out, .core_reset_out, .running_out);

/* sim/core_model.sv */
// core_model: core side, paces processor cycles and first fetches
// assumes core reset and stop recovery restart the core
`timescale 1ns/1ns
module core_model (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic core_reset_in,
	input wire logic stop_recover_in,
	output logic cycle_en_out,
	output logic first_instr_out
);
	logic [2:0] fetch_reg;
	// two clocks per cycle; fetch delay gives the window a clean start
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cycle_en_out <= 1'b0;
			fetch_reg <= 3'h4;
		end
		else
		begin
			cycle_en_out <= !cycle_en_out;
			if (core_reset_in | stop_recover_in)
				fetch_reg <= 3'h4;
			else
				fetch_reg <= fetch_reg >> 1;
		end
	end
	// first instruction after any reset or recovery
	assign first_instr_out = fetch_reg == 3'h1;
endmodule : core_model

/* sim/supervision_timer_tb_top.sv */
// tb top: register, service and timeout sequences with checks
// assumes an rc tick every clock when RC_DIV is 1
`timescale 1ns/1ns
module supervision_timer_tb_top
	import supervision_timer_pkg::*;
;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [3:0] bank_in = 4'h0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic [7:0] flags_in = 8'hff;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic service_in = 1'b0;
	logic halt_in = 1'b0;
	logic stop_in = 1'b0;
	logic stop_recover_in = 1'b0;
	logic [7:0] rdata_out, flags_out;
	logic flags_we_out, cycle_en_in, first_instr_in;
	logic core_reset_out, running_out;
	int error_cnt = 0;
	int checked = 0;
	int n;
	// 100 MHz clock
	initial forever #5 clock_in = ~clock_in;
	supervision_timer #(.RC_DIV(1)) supervision_timer_i (.clock_in,
		.resetn_in, .bank_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .service_in, .flags_in, .flags_out, .flags_we_out,
		.halt_in, .stop_in, .stop_recover_in, .first_instr_in,
		.cycle_en_in, .core_reset_out, .running_out);
	core_model core_model_i (.clock_in, .resetn_in,
		.core_reset_in(core_reset_out), .stop_recover_in,
		.cycle_en_out(cycle_en_in), .first_instr_out(first_instr_in));
	task cmp(input string s, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", s, e, g);
		end
	endtask : cmp
	task give_verdict();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task wr_reg(input logic [3:0] b, input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_in);
		bank_in <= b;
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask : wr_reg
	// read in bank f; data stand only in the next cycle
	task rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock_in);
		bank_in <= MODE_BANK;
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 cmp("rdata", 16'(e), 16'(rdata_out & m));
	endtask : rd_chk
	task service();
		@(posedge clock_in);
		service_in <= 1'b1;
		@(posedge clock_in);
		service_in <= 1'b0;
		#1 cmp("flags", 16'h00f8, 16'(flags_out));
		cmp("flag write", 16'h0001, 16'(flags_we_out));
		cmp("running", 16'h0001, 16'(running_out));
	endtask : service
	// bounded count of cycles until the core reset pulse
	task wait_rst(input int lim);
		n = 0;
		while (core_reset_out !== 1'b1 && n < lim)
		begin
			@(posedge clock_in);
			#1 n++;
		end
	endtask : wait_rst
	// main sequence
	initial
	begin
		repeat (20) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd_chk(MODE_ADDR, 8'hff, 8'h00);
		repeat (4) @(posedge clock_in);
		rd_chk(STATUS_ADDR, 8'h02, 8'h02);
		repeat (200) @(posedge clock_in);
		rd_chk(STATUS_ADDR, 8'h02, 8'h00);
		wr_reg(MODE_BANK, MODE_ADDR, 8'hf0);
		service();
		wait_rst(17000);
		cmp("locked tap", 16'd17000, 16'(n));
		service();
		@(posedge clock_in);
		stop_recover_in <= 1'b1;
		@(posedge clock_in);
		stop_recover_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		wr_reg(MODE_BANK, MODE_ADDR, 8'hf0);
		wr_reg(4'h0, MODE_ADDR, 8'h03);
		wr_reg(MODE_BANK, STATUS_ADDR, 8'h03);
		service();
		wait_rst(10000);
		cmp("refresh", 16'd10000, 16'(n));
		// mode bits 2 and 3 are clear now: halt, then stop, freeze the count
		service();
		@(posedge clock_in);
		halt_in <= 1'b1;
		wait_rst(17000);
		cmp("halt hold", 16'd17000, 16'(n));
		@(posedge clock_in);
		halt_in <= 1'b0;
		stop_in <= 1'b1;
		wait_rst(17000);
		cmp("stop hold", 16'd17000, 16'(n));
		@(posedge clock_in);
		stop_in <= 1'b0;
		service();
		wait_rst(16400);
		cmp("timeout", 16'h0001, 16'(n > 16378 && n < 16400));
		@(posedge clock_in);
		#1 cmp("stopped", 16'h0000, 16'(running_out));
		give_verdict();
	end
endmodule : supervision_timer_tb_top
